// ===== core/pc_stack.sv
// program counter, return address stack and fast shadow registers
`timescale 1ns/1ps
module pc_stack (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    reset_n,
  // core side
  input  wire pc_stack_pkg::core_req_s coreReq,
  input  wire logic                    coreResetIn,
  input  wire logic [15:0]             memWord,
  output logic [20:0]                  pcOut,
  output logic [15:0]                  fetchWord,
  output logic                         restoreValid,
  output pc_stack_pkg::shadow_s        restoreRegs,
  output logic                         stackReset,
  // register bus
  input  wire pc_stack_pkg::axi_req_s  axiReq,
  output pc_stack_pkg::axi_resp_s      axiResp
);

  pc_stack_pkg::state_s s_q;
  pc_stack_pkg::state_s s_d;

  // decoded core command
  logic isPush;
  logic isRet;
  logic isPopOnly;
  logic hwStack;
  logic swGo;
  logic [7:0] wByte;

  always_comb
  begin
    isPush    = coreReq.cmd inside {pc_stack_pkg::CMD_CALL, pc_stack_pkg::CMD_RELATIVE_CALL,
                                    pc_stack_pkg::CMD_INT, pc_stack_pkg::CMD_PUSH};
    isRet     = coreReq.cmd inside {pc_stack_pkg::CMD_RETURN, pc_stack_pkg::CMD_RETURN_LITERAL,
                                    pc_stack_pkg::CMD_RETURN_INTERRUPT};
    isPopOnly = coreReq.cmd == pc_stack_pkg::CMD_POP;
    // any command other than CMD_NONE or a plain step defers software writes
    hwStack   = coreReq.cmd != pc_stack_pkg::CMD_NONE && coreReq.cmd != pc_stack_pkg::CMD_STEP;
    swGo      = s_q.awHeld && s_q.wHeld && !s_q.bus.bvalid && !hwStack && !coreResetIn;
    wByte     = s_q.wData[7:0];
  end

  // read data of one register
  function automatic logic [31:0] readReg(input pc_stack_pkg::state_s st, input logic [7:0] a);
    logic [20:0] top;
    top = (st.ptr == pc_stack_pkg::PTR_EMPTY) ? 21'h000000 : st.entries[st.ptr];
    case (a)
      pc_stack_pkg::OFS_PC_LOW:      readReg = {24'h000000, st.pc[7:0]};
      pc_stack_pkg::OFS_HIGH_LATCH:  readReg = {24'h000000, st.highLatch};
      pc_stack_pkg::OFS_UPPER_LATCH: readReg = {27'h0000000, st.upperLatch};
      pc_stack_pkg::OFS_TOP_UPPER:   readReg = {27'h0000000, top[20:16]};
      pc_stack_pkg::OFS_TOP_HIGH:    readReg = {24'h000000, top[15:8]};
      pc_stack_pkg::OFS_TOP_LOW:     readReg = {24'h000000, top[7:0]};
      pc_stack_pkg::OFS_STACK_PTR:   readReg = {24'h000000, st.full, st.unf, 1'b0, st.ptr};
      pc_stack_pkg::OFS_CONFIG:      readReg = {31'h00000000, st.ovrEn};
      default:                       readReg = 32'h00000000;
    endcase
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = a inside {pc_stack_pkg::OFS_PC_LOW, pc_stack_pkg::OFS_HIGH_LATCH,
                       pc_stack_pkg::OFS_UPPER_LATCH, pc_stack_pkg::OFS_TOP_UPPER,
                       pc_stack_pkg::OFS_TOP_HIGH, pc_stack_pkg::OFS_TOP_LOW,
                       pc_stack_pkg::OFS_STACK_PTR, pc_stack_pkg::OFS_CONFIG};
  endfunction

  // next state: core command, stack, software access and bus handshakes
  always_comb
  begin
    logic        devReset;
    logic [4:0]  nPtr;
    logic [20:0] top;
    devReset = 1'b0;
    nPtr     = 5'h00;
    top      = 21'h000000;
    s_d      = s_q;
    s_d.restoreValid = 1'b0;
    s_d.stackReset   = 1'b0;

    // unimplemented space reads as zero so it runs as a no-operation
    s_d.fetchWord = (s_q.pc < pc_stack_pkg::IMPL_BYTES) ? memWord : 16'h0000;

    // counter update; latches are left alone by every core command
    case (coreReq.cmd)
      pc_stack_pkg::CMD_STEP, pc_stack_pkg::CMD_PUSH, pc_stack_pkg::CMD_POP:
        s_d.pc = 21'(s_q.pc + pc_stack_pkg::PC_STEP);
      pc_stack_pkg::CMD_GOTO, pc_stack_pkg::CMD_CALL, pc_stack_pkg::CMD_RELATIVE_CALL:
        s_d.pc = {coreReq.target[20:1], 1'b0};
      pc_stack_pkg::CMD_INT:
        s_d.pc = coreReq.vectorLow ? pc_stack_pkg::VECTOR_LOW
                                   : pc_stack_pkg::VECTOR_HIGH;
      default:
        s_d.pc = s_q.pc;
    endcase

    // shadow copy of status, working and bank registers
    if (coreReq.cmd == pc_stack_pkg::CMD_INT ||
        (coreReq.cmd == pc_stack_pkg::CMD_CALL && coreReq.fast))
    begin
      s_d.shadow = coreReq.regs;
    end
    if (coreReq.fast && (coreReq.cmd == pc_stack_pkg::CMD_RETURN_INTERRUPT ||
                         coreReq.cmd == pc_stack_pkg::CMD_RETURN))
    begin
      s_d.restoreValid = 1'b1;
      s_d.restore      = s_q.shadow;
    end

    // push: pointer first, then the entry; the pushed value is the current counter
    if (isPush)
    begin
      if (s_q.ptr == pc_stack_pkg::PTR_TOP)
      begin
        s_d.full = 1'b1;
        devReset = s_q.ovrEn;
      end
      else
      begin
        nPtr = 5'(s_q.ptr + 5'h01);
        s_d.ptr = nPtr;
        s_d.entries[nPtr] = s_q.pc;
        if (nPtr == pc_stack_pkg::PTR_TOP)
        begin
          s_d.full = 1'b1;
          devReset = s_q.ovrEn;
        end
      end
    end

    // pop: a return takes the entry to the counter first, then pointer down
    if (isRet || isPopOnly)
    begin
      if (s_q.ptr == pc_stack_pkg::PTR_EMPTY)
      begin
        s_d.unf = 1'b1;
        if (isRet)
        begin
          s_d.pc = pc_stack_pkg::RESET_VECTOR;
        end
        devReset = s_q.ovrEn;
      end
      else
      begin
        top = s_q.entries[s_q.ptr];
        if (isRet)
        begin
          s_d.pc = {top[20:1], 1'b0};
        end
        s_d.ptr = 5'(s_q.ptr - 5'h01);
      end
    end

    // stack reset clears counter and pointer; the flags survive it
    if (devReset || coreResetIn)
    begin
      s_d.stackReset = devReset;
      s_d.pc         = pc_stack_pkg::RESET_VECTOR;
      s_d.ptr        = pc_stack_pkg::PTR_EMPTY;
    end

    // write address and write data are taken independently
    if (axiReq.awvalid && s_q.bus.awready)
    begin
      s_d.awHeld      = 1'b1;
      s_d.awAddr      = axiReq.awaddr;
      s_d.bus.awready = 1'b0;
    end
    if (axiReq.wvalid && s_q.bus.wready)
    begin
      s_d.wHeld      = 1'b1;
      s_d.wData      = axiReq.wdata;
      s_d.wStrb      = axiReq.wstrb;
      s_d.bus.wready = 1'b0;
    end

    // register write, held back while the core moves the stack
    if (swGo)
    begin
      s_d.bus.bvalid = 1'b1;
      s_d.bus.bresp  = mapped(s_q.awAddr) ? pc_stack_pkg::RESP_OKAY
                                          : pc_stack_pkg::RESP_SLVERR;
      top = s_q.entries[s_q.ptr];
      if (s_q.wStrb[0])
      begin
        case (s_q.awAddr)
          pc_stack_pkg::OFS_PC_LOW:
            s_d.pc = {s_q.upperLatch, s_q.highLatch, wByte[7:1], 1'b0};
          pc_stack_pkg::OFS_HIGH_LATCH:
            s_d.highLatch = wByte;
          pc_stack_pkg::OFS_UPPER_LATCH:
            s_d.upperLatch = wByte[4:0];
          pc_stack_pkg::OFS_TOP_UPPER:
            if (s_q.ptr != pc_stack_pkg::PTR_EMPTY)
            begin
              s_d.entries[s_q.ptr] = {wByte[4:0], top[15:0]};
            end
          pc_stack_pkg::OFS_TOP_HIGH:
            if (s_q.ptr != pc_stack_pkg::PTR_EMPTY)
            begin
              s_d.entries[s_q.ptr] = {top[20:16], wByte, top[7:0]};
            end
          pc_stack_pkg::OFS_TOP_LOW:
            if (s_q.ptr != pc_stack_pkg::PTR_EMPTY)
            begin
              s_d.entries[s_q.ptr] = {top[20:8], wByte};
            end
          pc_stack_pkg::OFS_STACK_PTR:
          begin
            // flags only clear; hardware never sets them in this cycle
            s_d.full = s_q.full & wByte[pc_stack_pkg::FULL_BIT];
            s_d.unf  = s_q.unf & wByte[pc_stack_pkg::UNF_BIT];
            s_d.ptr  = wByte[4:0];
          end
          pc_stack_pkg::OFS_CONFIG:
            s_d.ovrEn = wByte[pc_stack_pkg::CFG_OVR_BIT];
          default:
            s_d.ovrEn = s_q.ovrEn;
        endcase
      end
    end

    // write response retires and frees both channels
    if (s_q.bus.bvalid && axiReq.bready)
    begin
      s_d.bus.bvalid  = 1'b0;
      s_d.awHeld      = 1'b0;
      s_d.wHeld       = 1'b0;
      s_d.bus.awready = 1'b1;
      s_d.bus.wready  = 1'b1;
    end

    // read: data one cycle after the address is taken
    if (axiReq.arvalid && s_q.bus.arready)
    begin
      s_d.bus.arready = 1'b0;
      s_d.bus.rvalid  = 1'b1;
      s_d.bus.rdata   = readReg(s_q, axiReq.araddr);
      s_d.bus.rresp   = mapped(axiReq.araddr) ? pc_stack_pkg::RESP_OKAY
                                              : pc_stack_pkg::RESP_SLVERR;
      if (axiReq.araddr == pc_stack_pkg::OFS_PC_LOW)
      begin
        s_d.highLatch  = s_q.pc[15:8];
        s_d.upperLatch = s_q.pc[20:16];
      end
    end
    if (s_q.bus.rvalid && axiReq.rready)
    begin
      s_d.bus.rvalid  = 1'b0;
      s_d.bus.arready = 1'b1;
    end
  end

  // power-on reset clears flags too, along with the stack array and the rest of the state except the overflow enable and the three ready bits, which are set
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      s_q             <= '0;
      s_q.pc          <= pc_stack_pkg::RESET_VECTOR;
      s_q.ptr         <= pc_stack_pkg::PTR_EMPTY;
      s_q.ovrEn       <= pc_stack_pkg::CONFIG_RESET[pc_stack_pkg::CFG_OVR_BIT];
      s_q.bus.awready <= 1'b1;
      s_q.bus.wready  <= 1'b1;
      s_q.bus.arready <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state register
  assign pcOut        = s_q.pc;
  assign fetchWord    = s_q.fetchWord;
  assign restoreValid = s_q.restoreValid;
  assign restoreRegs  = s_q.restore;
  assign stackReset   = s_q.stackReset;
  assign axiResp      = s_q.bus;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  logic plainPush;
  assign plainPush = isPush && !coreResetIn && s_q.ptr < pc_stack_pkg::PTR_NEXT_TOP;

  sequence pushTaken;
    plainPush;
  endsequence

  sequence pushLanded;
    s_q.ptr == 5'($past(s_q.ptr) + 5'h01) && s_q.entries[s_q.ptr] == $past(s_q.pc);
  endsequence

  a_pc_even: assert property (s_q.pc[0] == 1'b0)
    else $error("counter bit 0 is set");
  a_step_two: assert property ((coreReq.cmd == pc_stack_pkg::CMD_STEP && !swGo
    && !coreResetIn) |=> s_q.pc == 21'($past(s_q.pc) + pc_stack_pkg::PC_STEP))
    else $error("sequential step did not add two");
  a_int_vector: assert property ((coreReq.cmd == pc_stack_pkg::CMD_INT && plainPush)
    |=> s_q.pc == ($past(coreReq.vectorLow) ? pc_stack_pkg::VECTOR_LOW
                                             : pc_stack_pkg::VECTOR_HIGH))
    else $error("wrong interrupt vector");
  a_push_order: assert property (pushTaken |=> pushLanded)
    else $error("push did not increment and store");
  a_pop_empty: assert property ((isRet && s_q.ptr == pc_stack_pkg::PTR_EMPTY
    && !coreResetIn) |=> s_q.pc == pc_stack_pkg::RESET_VECTOR && s_q.unf
    && s_q.ptr == pc_stack_pkg::PTR_EMPTY)
    else $error("underflow pop mishandled");
  a_full_sticky: assert property ((s_q.full && !swGo) |=> s_q.full)
    else $error("full flag dropped without software");
  a_ovr_reset: assert property ((isPush && s_q.ovrEn
    && s_q.ptr == pc_stack_pkg::PTR_NEXT_TOP)
    |=> s_q.stackReset && s_q.full && s_q.ptr == pc_stack_pkg::PTR_EMPTY
        && s_q.entries[pc_stack_pkg::PTR_TOP] == $past(s_q.pc))
    else $error("overflow reset sequence wrong");
  a_ovr_hold: assert property ((isPush && !s_q.ovrEn && !coreResetIn
    && s_q.ptr == pc_stack_pkg::PTR_TOP) |=> s_q.ptr == pc_stack_pkg::PTR_TOP
    && s_q.entries[pc_stack_pkg::PTR_TOP] == $past(s_q.entries[pc_stack_pkg::PTR_TOP]))
    else $error("push past full moved the stack");
  a_low_write: assert property ((swGo && s_q.awAddr == pc_stack_pkg::OFS_PC_LOW
    && s_q.wStrb[0]) |=> s_q.pc[20:8] == $past({s_q.upperLatch, s_q.highLatch}))
    else $error("low byte write did not copy latches");
  a_fetch_gap: assert property ((s_q.pc >= pc_stack_pkg::IMPL_BYTES)
    |=> fetchWord == 16'h0000)
    else $error("fetch beyond memory not zero");
  a_shadow_back: assert property ((coreReq.cmd == pc_stack_pkg::CMD_RETURN_INTERRUPT
    && coreReq.fast) |=> restoreValid && restoreRegs == $past(s_q.shadow))
    else $error("fast return did not restore shadow");
  // a return must take the selected entry, even-aligned, and step the pointer down
  a_ret_pop: assert property ((isRet && s_q.ptr != pc_stack_pkg::PTR_EMPTY
    && !coreResetIn) |=> s_q.pc == ($past(s_q.entries[s_q.ptr]) & 21'h1ffffe)
    && s_q.ptr == 5'($past(s_q.ptr) - 5'h01))
    else $error("return did not pop the top entry");
  a_pop_only: assert property ((isPopOnly && s_q.ptr != pc_stack_pkg::PTR_EMPTY
    && !coreResetIn) |=> s_q.ptr == 5'($past(s_q.ptr) - 5'h01)
    && s_q.pc == 21'($past(s_q.pc) + pc_stack_pkg::PC_STEP))
    else $error("pop instruction mishandled");
  a_unf_sticky: assert property ((s_q.unf && !swGo) |=> s_q.unf)
    else $error("underflow flag dropped without software");
  a_core_reset: assert property (coreResetIn
    |=> s_q.ptr == pc_stack_pkg::PTR_EMPTY && s_q.pc == pc_stack_pkg::RESET_VECTOR)
    else $error("core reset left the stack");
  // latches move only by software or by a low byte read
  a_low_read: assert property ((axiReq.arvalid && s_q.bus.arready
    && axiReq.araddr == pc_stack_pkg::OFS_PC_LOW)
    |=> {s_q.upperLatch, s_q.highLatch} == $past(s_q.pc[20:8]))
    else $error("low byte read did not load latches");
  a_latch_keep: assert property ((hwStack && !(axiReq.arvalid && s_q.bus.arready
    && axiReq.araddr == pc_stack_pkg::OFS_PC_LOW)) |=> $stable(s_q.highLatch)
    && $stable(s_q.upperLatch))
    else $error("core command touched a latch");
  a_shadow_load: assert property ((coreReq.cmd == pc_stack_pkg::CMD_INT
    || (coreReq.cmd == pc_stack_pkg::CMD_CALL && coreReq.fast))
    |=> s_q.shadow == $past(coreReq.regs))
    else $error("shadow copy not loaded");
endmodule

// ===== dv/core_model.sv
// decoder and program memory stand-in facing the counter block
`timescale 1ns/1ps
module core_model (
  // bench command
  input  wire pc_stack_pkg::core_req_s reqIn,
  // counter block side
  input  wire logic [20:0]             pcOut,
  output pc_stack_pkg::core_req_s      coreReq,
  output logic [15:0]                  memWord
);
  // one command a cycle; the array answers at the current counter
  always_comb
  begin
    coreReq = reqIn;
    // above the array the bus floats, so show a moving pattern of inverted counter bits
    if (pcOut >= pc_stack_pkg::IMPL_BYTES)
      memWord = ~pcOut[16:1];
    else
      memWord = pcOut[16:1] ^ 16'h5a5a;
  end
endmodule

// ===== dv/test_program_counter_return_stack.sv
// self-checking bench for the program counter and return stack
`timescale 1ns/1ps
module test_program_counter_return_stack;
  logic                      clk = 1'b0;
  logic                      reset_n = 1'b0;
  logic                      coreResetIn = 1'b0;
  pc_stack_pkg::core_req_s   reqIn = '0;
  pc_stack_pkg::core_req_s   coreReq;
  pc_stack_pkg::axi_req_s    axiReq = '0;
  pc_stack_pkg::axi_resp_s   axiResp;
  pc_stack_pkg::shadow_s     restoreRegs;
  logic [20:0]               pcOut;
  logic [20:0]               topVal;
  logic [15:0]               memWord;
  logic [15:0]               fetchWord;
  logic                      restoreValid;
  logic                      stackReset;
  logic [31:0]               rd;
  logic [1:0]                rsp;
  int                        errTotal = 0;
  int                        checksDone = 0;
  int                        resets = 0;

  // 100 MHz core clock
  always #5 clk = ~clk;
  // count device reset requests from the stack
  always @(posedge clk)
    if (stackReset === 1'b1)
      resets++;

  core_model PARTNER (.reqIn(reqIn), .pcOut(pcOut), .coreReq(coreReq), .memWord(memWord));
  pc_stack DUT (.clk(clk), .reset_n(reset_n), .coreReq(coreReq), .coreResetIn(coreResetIn),
    .memWord(memWord), .pcOut(pcOut), .fetchWord(fetchWord), .restoreValid(restoreValid),
    .restoreRegs(restoreRegs), .stackReset(stackReset), .axiReq(axiReq), .axiResp(axiResp));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp)
    begin
      errTotal++;
      $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic completeRun();
    $display("checks %0d mismatches %0d", checksDone, errTotal);
    if (errTotal == 0 && checksDone > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // one write; address and data offered together, bready held until bvalid
  task automatic regWrite(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    axiReq.awvalid <= 1'b1;
    axiReq.awaddr <= a;
    axiReq.wvalid <= 1'b1;
    axiReq.wdata <= {24'h000000, v};
    axiReq.wstrb <= 4'hf;
    axiReq.bready <= 1'b1;
    forever
    begin
      @(posedge clk);
      if (axiReq.awvalid && axiResp.awready)
        axiReq.awvalid <= 1'b0;
      if (axiReq.wvalid && axiResp.wready)
        axiReq.wvalid <= 1'b0;
      if (axiResp.bvalid)
      begin
        rsp = axiResp.bresp;
        axiReq.bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic regRead(input logic [7:0] a);
    @(posedge clk);
    axiReq.arvalid <= 1'b1;
    axiReq.araddr <= a;
    axiReq.rready <= 1'b1;
    forever
    begin
      @(posedge clk);
      if (axiReq.arvalid && axiResp.arready)
        axiReq.arvalid <= 1'b0;
      if (axiResp.rvalid)
      begin
        rd = axiResp.rdata;
        rsp = axiResp.rresp;
        axiReq.rready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic expectReg(input logic [7:0] a, input logic [7:0] v);
    regRead(a);
    check(rd, {24'h000000, v});
  endtask

  // the core issues no commands here, so no interrupt can touch the stack
  task automatic readTop();
    regRead(pc_stack_pkg::OFS_TOP_UPPER);
    topVal[20:16] = rd[4:0];
    regRead(pc_stack_pkg::OFS_TOP_HIGH);
    topVal[15:8] = rd[7:0];
    regRead(pc_stack_pkg::OFS_TOP_LOW);
    topVal[7:0] = rd[7:0];
  endtask

  // one command for one edge, then idle; f doubles as the vector select
  task automatic coreOp(input pc_stack_pkg::core_cmd_e c, input logic f,
                        input logic [20:0] t, input logic [23:0] r);
    @(posedge clk);
    reqIn.cmd <= c;
    reqIn.fast <= f;
    reqIn.vectorLow <= f;
    reqIn.target <= t;
    reqIn.regs <= r;
    @(posedge clk);
    reqIn.cmd <= pc_stack_pkg::CMD_NONE;
    #1;
  endtask

  task automatic testReset();
    check(32'(pcOut), 32'h000000);
    expectReg(pc_stack_pkg::OFS_STACK_PTR, 8'h00);
    expectReg(pc_stack_pkg::OFS_CONFIG, 8'h01);
    regRead(8'h40);
    check(32'(rsp), 32'(pc_stack_pkg::RESP_SLVERR));
    check(rd, 32'h00000000);
    regWrite(8'h40, 8'h5a);
    check(32'(rsp), 32'(pc_stack_pkg::RESP_SLVERR));
    $display("reset test done");
  endtask

  task automatic testFetch();
    coreOp(pc_stack_pkg::CMD_GOTO, 0, 21'h003ffd, 0);
    check(32'(pcOut), 32'h003ffc);
    @(posedge clk);
    #1;
    check(32'(fetchWord), 32'(16'h1ffe ^ 16'h5a5a));
    coreOp(pc_stack_pkg::CMD_STEP, 0, 0, 0);
    coreOp(pc_stack_pkg::CMD_STEP, 0, 0, 0);
    check(32'(pcOut), 32'h004000);
    @(posedge clk);
    #1;
    check(32'(fetchWord), 32'h0);
    coreOp(pc_stack_pkg::CMD_GOTO, 0, 21'h1ffffe, 0);
    coreOp(pc_stack_pkg::CMD_STEP, 0, 0, 0);
    check(32'(pcOut), 32'h0);
    $display("fetch test done");
  endtask

  task automatic testLatches();
    regWrite(pc_stack_pkg::OFS_HIGH_LATCH, 8'h12);
    check(32'(rsp), 32'(pc_stack_pkg::RESP_OKAY));
    regWrite(pc_stack_pkg::OFS_UPPER_LATCH, 8'h03);
    coreOp(pc_stack_pkg::CMD_GOTO, 0, 21'h000200, 0);
    check(32'(pcOut), 32'h000200);
    regWrite(pc_stack_pkg::OFS_PC_LOW, 8'h57);
    check(32'(pcOut), 32'h031256);
    coreOp(pc_stack_pkg::CMD_GOTO, 0, 21'h0a5678, 0);
    expectReg(pc_stack_pkg::OFS_PC_LOW, 8'h78);
    expectReg(pc_stack_pkg::OFS_HIGH_LATCH, 8'h56);
    expectReg(pc_stack_pkg::OFS_UPPER_LATCH, 8'h0a);
    $display("latch test done");
  endtask

  task automatic testCalls();
    regWrite(pc_stack_pkg::OFS_HIGH_LATCH, 8'h77);
    coreOp(pc_stack_pkg::CMD_GOTO, 0, 21'h000100, 0);
    coreOp(pc_stack_pkg::CMD_RELATIVE_CALL, 0, 21'h001234, 0);
    check(32'(pcOut), 32'h001234);
    expectReg(pc_stack_pkg::OFS_STACK_PTR, 8'h01);
    readTop();
    check(32'(topVal), 32'h000100);
    // an odd byte in the entry must still return to an even address
    regWrite(pc_stack_pkg::OFS_TOP_LOW, 8'h41);
    coreOp(pc_stack_pkg::CMD_RETURN_LITERAL, 0, 0, 0);
    check(32'(pcOut), 32'h000140);
    expectReg(pc_stack_pkg::OFS_STACK_PTR, 8'h00);
    expectReg(pc_stack_pkg::OFS_HIGH_LATCH, 8'h77);
    coreOp(pc_stack_pkg::CMD_PUSH, 0, 0, 0);
    readTop();
    check(32'(topVal), 32'h000140);
    coreOp(pc_stack_pkg::CMD_POP, 0, 0, 0);
    expectReg(pc_stack_pkg::OFS_STACK_PTR, 8'h00);
    $display("call test done");
  endtask

  task automatic testShadow();
    coreOp(pc_stack_pkg::CMD_GOTO, 0, 21'h000600, 0);
    coreOp(pc_stack_pkg::CMD_INT, 0, 0, 24'h112233);
    check(32'(pcOut), 32'h000008);
    coreOp(pc_stack_pkg::CMD_INT, 1, 0, 24'h445566);
    check(32'(pcOut), 32'h000018);
    coreOp(pc_stack_pkg::CMD_RETURN_INTERRUPT, 1, 0, 0);
    check(32'(restoreValid), 32'h1);
    check(32'(restoreRegs), 32'h445566);
    check(32'(pcOut), 32'h000008);
    coreOp(pc_stack_pkg::CMD_RETURN_INTERRUPT, 0, 0, 0);
    check(32'(restoreValid), 32'h0);
    check(32'(pcOut), 32'h000600);
    coreOp(pc_stack_pkg::CMD_CALL, 1, 21'h000700, 24'h778899);
    coreOp(pc_stack_pkg::CMD_RETURN, 1, 0, 0);
    check(32'(restoreValid), 32'h1);
    check(32'(restoreRegs), 32'h778899);
    $display("shadow test done");
  endtask

  task automatic testLimits();
    regWrite(pc_stack_pkg::OFS_CONFIG, 8'h00);
    for (int i = 0; i < 31; i++)
      coreOp(pc_stack_pkg::CMD_CALL, 0, 21'h000800 + 21'(i * 4), 0);
    expectReg(pc_stack_pkg::OFS_STACK_PTR, 8'h9f);
    coreOp(pc_stack_pkg::CMD_CALL, 0, 21'h000a00, 0);
    expectReg(pc_stack_pkg::OFS_STACK_PTR, 8'h9f);
    readTop();
    check(32'(topVal), 32'h000874);
    regWrite(pc_stack_pkg::OFS_STACK_PTR, 8'h00);
    expectReg(pc_stack_pkg::OFS_STACK_PTR, 8'h00);
    coreOp(pc_stack_pkg::CMD_RETURN, 0, 0, 0);
    check(32'(pcOut), 32'h0);
    expectReg(pc_stack_pkg::OFS_STACK_PTR, 8'h40);
    check(32'(resets), 32'h0);
    regWrite(pc_stack_pkg::OFS_CONFIG, 8'h01);
    regWrite(pc_stack_pkg::OFS_STACK_PTR, 8'h1e);
    coreOp(pc_stack_pkg::CMD_CALL, 0, 21'h000b00, 0);
    // the reset lands on the push that fills the stack, so the second call is skipped
    if (stackReset !== 1'b1)
      coreOp(pc_stack_pkg::CMD_CALL, 0, 21'h000c00, 0);
    repeat (2) @(posedge clk);
    check(32'(resets), 32'h1);
    check(32'(pcOut), 32'h0);
    expectReg(pc_stack_pkg::OFS_STACK_PTR, 8'h80);
    regWrite(pc_stack_pkg::OFS_STACK_PTR, 8'h00);
    coreOp(pc_stack_pkg::CMD_RETURN, 0, 0, 0);
    repeat (2) @(posedge clk);
    check(32'(resets), 32'h2);
    expectReg(pc_stack_pkg::OFS_STACK_PTR, 8'h40);
    $display("limit test done");
  endtask

  // core reset keeps the flags, a mid-run power-on reset clears them
  task automatic testResets();
    coreOp(pc_stack_pkg::CMD_CALL, 0, 21'h000d00, 0);
    @(posedge clk);
    coreResetIn <= 1'b1;
    @(posedge clk);
    coreResetIn <= 1'b0;
    #1;
    check(32'(pcOut), 32'h0);
    expectReg(pc_stack_pkg::OFS_STACK_PTR, 8'h40);
    regWrite(pc_stack_pkg::OFS_CONFIG, 8'h00);
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    expectReg(pc_stack_pkg::OFS_STACK_PTR, 8'h00);
    expectReg(pc_stack_pkg::OFS_CONFIG, 8'h01);
    $display("reset pair test done");
  endtask

  // main sequence after 20 cycles of reset
  initial
  begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    #1;
    testReset();
    testFetch();
    testLatches();
    testCalls();
    testShadow();
    testLimits();
    testResets();
    completeRun();
  end

  // the whole run needs a few hundred cycles; this cuts a hang short
  initial
  begin
    #500000;
    errTotal++;
    completeRun();
  end
endmodule

// ===== inc/pc_stack_pkg.sv
// constants, commands and carriers of the program counter and return stack
package pc_stack_pkg;
  // program counter
  localparam int          PC_W         = 21;
  localparam logic [20:0] PC_STEP      = 21'h000002;
  localparam logic [20:0] RESET_VECTOR = 21'h000000;
  localparam logic [20:0] VECTOR_HIGH  = 21'h000008;
  localparam logic [20:0] VECTOR_LOW   = 21'h000018;
  localparam logic [20:0] IMPL_BYTES   = 21'h004000; // implemented program memory
  // return stack
  localparam logic [4:0]  PTR_TOP      = 5'h1f;
  localparam logic [4:0]  PTR_NEXT_TOP = 5'h1e;
  localparam logic [4:0]  PTR_EMPTY    = 5'h00;
  localparam int          FULL_BIT     = 7;
  localparam int          UNF_BIT      = 6;
  localparam int          CFG_OVR_BIT  = 0;
  localparam logic [7:0]  CONFIG_RESET = 8'h01;  // overflow reset enabled by default
  // register byte addresses
  localparam logic [7:0]  OFS_PC_LOW      = 8'h00;
  localparam logic [7:0]  OFS_HIGH_LATCH  = 8'h04;
  localparam logic [7:0]  OFS_UPPER_LATCH = 8'h08;
  localparam logic [7:0]  OFS_TOP_UPPER   = 8'h0c;
  localparam logic [7:0]  OFS_TOP_HIGH    = 8'h10;
  localparam logic [7:0]  OFS_TOP_LOW     = 8'h14;
  localparam logic [7:0]  OFS_STACK_PTR   = 8'h18;
  localparam logic [7:0]  OFS_CONFIG      = 8'h1c;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  typedef enum logic [3:0] {
    CMD_NONE, CMD_STEP, CMD_GOTO, CMD_CALL, CMD_RELATIVE_CALL, CMD_INT,
    CMD_RETURN, CMD_RETURN_LITERAL, CMD_RETURN_INTERRUPT, CMD_PUSH, CMD_POP
  } core_cmd_e;

  typedef struct packed {
    logic [7:0] status;
    logic [7:0] work;
    logic [7:0] bank;
  } shadow_s;

  typedef struct packed {
    core_cmd_e   cmd;
    logic        fast;
    logic        vectorLow;
    logic [20:0] target;
    shadow_s     regs;
  } core_req_s;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } axi_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axi_resp_s;

  typedef struct packed {
    logic [20:0]        pc;
    logic [7:0]         highLatch;
    logic [4:0]         upperLatch;
    logic [4:0]         ptr;
    logic               full;
    logic               unf;
    logic               ovrEn;
    logic [31:1][20:0]  entries;
    shadow_s            shadow;
    logic               restoreValid;
    shadow_s            restore;
    logic [15:0]        fetchWord;
    logic               stackReset;
    logic               awHeld;
    logic [7:0]         awAddr;
    logic               wHeld;
    logic [31:0]        wData;
    logic [3:0]         wStrb;
    axi_resp_s          bus;
  } state_s;
endpackage
